// ### inc/mimb_params.svh
// Register offsets, field positions and reset values for the mask bank
// Assumes inclusion by the package and the design file only
`ifndef MIMB_PARAMS_SVH
`define MIMB_PARAMS_SVH

`define MIMB_OFS_TACH_MASK 8'h1A
`define MIMB_OFS_MISC_MASK 8'h1B
`define MIMB_OFS_GPLO_MASK 8'h1C
`define MIMB_OFS_GPHI_MASK 8'h1D
`define MIMB_OFS_TEMP_OFFSET 8'h1E
`define MIMB_OFS_TEMP_VALUE 8'h1F

`define MIMB_RST_MASK 8'h00
`define MIMB_RST_OFFSET 8'h00
`define MIMB_RST_VALUE 8'h00
`define MIMB_RD_UNMAPPED 8'h00

`define MIMB_MISC_INT_TEMP 0
`define MIMB_MISC_VBAT 1
`define MIMB_MISC_AUX8 2
`define MIMB_MISC_THERMAL 3
`define MIMB_MISC_AFC 4
`define MIMB_MISC_UNUSED 5
`define MIMB_MISC_CHASSIS 6
`define MIMB_MISC_GENERAL_IO_SIXTEEN 7

`define MIMB_MISC_WR_MASK 8'hDF
`define MIMB_TEMP_MAX 8'h7F
`define MIMB_TEMP_MIN 8'h80

`endif

// ### inc/mimb_pkg.sv
// Types shared by the mask bank and its surroundings
// Assumes mimb_params.svh is on the include path
`include "mimb_params.svh"

package mimb_pkg;

   // Byte-wide register access from the serial management front end
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } mimb_reg_req_t;

   // Per-source conditions seen on one conversion cycle
   typedef struct packed {
      logic [7:0] tach_over;
      logic vbat_out;
      logic aux_analog_eight_out;
      logic thermal_limit_event;
      logic auto_fan_control_event;
      logic chassis_intrusion;
      logic general_io_sixteen;
      logic [15:0] general_io;
   } mimb_src_t;

   // Internal temperature measurement and its limits
   typedef struct packed {
      logic valid;
      logic [7:0] raw;
      logic [7:0] high_limit;
      logic [7:0] low_limit;
   } mimb_temp_t;

endpackage : mimb_pkg

// ### hdl/mimb_mask_bank.sv
// Interrupt mask bank, status capture and internal temperature offset
// Assumes a front end that issues byte register accesses in sys_clk_i
// Functional notes
// - Register 1A bit n masks fan tach channel n when set.
// - Register 1B bits 0,1,2 mask int temp, battery, aux analog eight.
// - Register 1B bit 3 masks thermal-limit event interrupts.
// - Register 1B bit 4 masks automatic fan control event interrupts.
// - Register 1B bit 5 reads zero; writes to it are ignored.
// - Register 1B bit 6 masks chassis intrusion interrupts.
// - Register 1B bit 7 masks general I/O sixteen interrupts.
// - Register 1C bit n masks general I/O channel n, 0 to 7.
// - Register 1D bit n masks general I/O channel n plus 8.
// - All mask registers are zero after reset.
// - Signed offset is added to each temperature before store and compare.
// - Offset register is 8-bit read/write two's complement, resets zero.
// - Corrected temperature readable at 1F, read-only, resets zero.
// - Status bit follows out-of-limit condition of previous conversion.
`timescale 1ns/10ps
`default_nettype none
`include "mimb_params.svh"

module mimb_mask_bank
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire mimb_pkg::mimb_reg_req_t reg_req_i,
   input wire logic conv_done_i,
   input wire mimb_pkg::mimb_src_t src_i,
   input wire mimb_pkg::mimb_temp_t temp_i,
   output logic [7:0] rd_data_o,
   output logic irq_o,
   output logic [31:0] status_o,
   output logic [7:0] int_temp_value_o
);
   import mimb_pkg::*;

   logic [7:0] tach_mask_r;
   logic [7:0] misc_mask_r;
   logic [7:0] gplo_mask_r;
   logic [7:0] gphi_mask_r;
   logic [7:0] temp_offset_r;
   logic [7:0] temp_value_r;
   logic temp_fault_r;
   logic [31:0] status_r;
   logic [31:0] status_nxt;
   logic [31:0] mask_all;
   logic [7:0] corrected;
   logic [8:0] sum;
   logic [7:0] rd_data_r;
   logic irq_r;

   function automatic logic wr_hit(input mimb_reg_req_t req,
                                   input logic [7:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction : wr_hit

   // Mask registers; only the addressed one changes on a write
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         tach_mask_r <= `MIMB_RST_MASK;
         misc_mask_r <= `MIMB_RST_MASK;
         gplo_mask_r <= `MIMB_RST_MASK;
         gphi_mask_r <= `MIMB_RST_MASK;
      end
      else
      begin
         if (wr_hit(reg_req_i, `MIMB_OFS_TACH_MASK))
            tach_mask_r <= reg_req_i.wdata;
         if (wr_hit(reg_req_i, `MIMB_OFS_MISC_MASK))
            misc_mask_r <= reg_req_i.wdata & `MIMB_MISC_WR_MASK;
         if (wr_hit(reg_req_i, `MIMB_OFS_GPLO_MASK))
            gplo_mask_r <= reg_req_i.wdata;
         if (wr_hit(reg_req_i, `MIMB_OFS_GPHI_MASK))
            gphi_mask_r <= reg_req_i.wdata;
      end
   end

   // Offset register
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         temp_offset_r <= `MIMB_RST_OFFSET;
      else if (wr_hit(reg_req_i, `MIMB_OFS_TEMP_OFFSET))
         temp_offset_r <= reg_req_i.wdata;
   end

   // Signed add with clamp; a wrap would turn a hot reading cold
   always_comb
   begin
      sum = {temp_i.raw[7], temp_i.raw} + {temp_offset_r[7], temp_offset_r};
      if (sum[8] != sum[7])
         corrected = sum[8] ? `MIMB_TEMP_MIN : `MIMB_TEMP_MAX;
      else
         corrected = sum[7:0];
   end

   // Corrected value stored and compared; limits are signed as well
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         temp_value_r <= `MIMB_RST_VALUE;
         temp_fault_r <= 1'b0;
      end
      else if (temp_i.valid)
      begin
         temp_value_r <= corrected;
         temp_fault_r <= ($signed(corrected) > $signed(temp_i.high_limit)) ||
                         ($signed(corrected) < $signed(temp_i.low_limit));
      end
   end

   // Status layout: [7:0] tach, [15:8] misc, [31:16] general I/O
   always_comb
   begin
      status_nxt = {src_i.general_io,
                    src_i.general_io_sixteen,
                    src_i.chassis_intrusion,
                    1'b0,
                    src_i.auto_fan_control_event,
                    src_i.thermal_limit_event,
                    src_i.aux_analog_eight_out,
                    src_i.vbat_out,
                    temp_fault_r,
                    src_i.tach_over};
   end

   // Whole status follows each conversion, independent of the masks
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         status_r <= 32'h0000_0000;
      else if (conv_done_i)
         status_r <= status_nxt;
   end

   assign mask_all = {gphi_mask_r, gplo_mask_r, misc_mask_r, tach_mask_r};

   // Only the interrupt path sees the masks
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         irq_r <= 1'b0;
      else
         irq_r <= |(status_r & ~mask_all);
   end

   // Read data follows the address one cycle later
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         rd_data_r <= `MIMB_RD_UNMAPPED;
      else
      begin
         case (reg_req_i.addr)
            `MIMB_OFS_TACH_MASK: rd_data_r <= tach_mask_r;
            `MIMB_OFS_MISC_MASK: rd_data_r <= misc_mask_r;
            `MIMB_OFS_GPLO_MASK: rd_data_r <= gplo_mask_r;
            `MIMB_OFS_GPHI_MASK: rd_data_r <= gphi_mask_r;
            `MIMB_OFS_TEMP_OFFSET: rd_data_r <= temp_offset_r;
            `MIMB_OFS_TEMP_VALUE: rd_data_r <= temp_value_r;
            default: rd_data_r <= `MIMB_RD_UNMAPPED;
         endcase
      end
   end

   assign rd_data_o = rd_data_r;
   assign irq_o = irq_r;
   assign status_o = status_r;
   assign int_temp_value_o = temp_value_r;

endmodule : mimb_mask_bank
`default_nettype wire

// ### verif/mimb_mask_bank_asserts.sv
// Port checker for the interrupt mask bank
// Assumes it is bound onto every mask bank instance
`timescale 1ns/10ps
`default_nettype none
module mimb_mask_bank_asserts
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire mimb_pkg::mimb_reg_req_t reg_req_i,
   input wire logic conv_done_i,
   input wire mimb_pkg::mimb_src_t src_i,
   input wire mimb_pkg::mimb_temp_t temp_i,
   input wire logic [7:0] rd_data_o,
   input wire logic irq_o,
   input wire logic [31:0] status_o,
   input wire logic [7:0] int_temp_value_o
);
   import mimb_pkg::*;
   logic [7:0] ofs_r;
   logic [7:0] tmask_r;
   logic signed [8:0] sum;
   logic [7:0] exp_v;
   assign sum = $signed(temp_i.raw) + $signed(ofs_r);
   assign exp_v = sum > 9'sh07F ? 8'h7F : sum < 9'sh180 ? 8'h80 : sum[7:0];
   // Shadow copies, so irq and temperature can be judged from the ports
   always_ff @(posedge sys_clk_i)
      if (reset_i)
         ofs_r <= 8'h00;
      else if (reg_req_i.wr && reg_req_i.addr == 8'h1E)
         ofs_r <= reg_req_i.wdata;
   always_ff @(posedge sys_clk_i)
      if (reset_i)
         tmask_r <= 8'h00;
      else if (reg_req_i.wr && reg_req_i.addr == 8'h1A)
         tmask_r <= reg_req_i.wdata;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_reset_clear: assert property ($fell(reset_i) |->
      status_o == 32'h0000_0000 && !irq_o && int_temp_value_o == 8'h00)
      else $error("outputs not clear after reset");
   a_rw_readback: assert property (
      reg_req_i.wr && reg_req_i.addr inside {8'h1A, 8'h1C, 8'h1D, 8'h1E}
      ##1 reg_req_i.addr == $past(reg_req_i.addr)
      |=> rd_data_o == $past(reg_req_i.wdata, 2))
      else $error("register readback wrong");
   a_misc_readback: assert property (
      reg_req_i.wr && reg_req_i.addr == 8'h1B ##1 reg_req_i.addr == 8'h1B
      |=> rd_data_o == ($past(reg_req_i.wdata, 2) & 8'hDF))
      else $error("misc mask readback wrong");
   a_value_ro: assert property (
      reg_req_i.wr && reg_req_i.addr == 8'h1F && !temp_i.valid
      |=> $stable(int_temp_value_o)) else $error("value register written");
   a_temp_sum: assert property (temp_i.valid |=>
      int_temp_value_o == $past(exp_v)) else $error("corrected value wrong");
   a_status_load: assert property (conv_done_i |=>
      status_o[7:0] == $past(src_i.tach_over) && !status_o[13]
      && status_o[31:16] == $past(src_i.general_io))
      else $error("status not loaded from sources");
   a_status_hold: assert property (!conv_done_i |=>
      $stable(status_o)) else $error("status moved between conversions");
   a_tach_irq: assert property (|(status_o[7:0] & ~tmask_r) |=>
      irq_o) else $error("unmasked tach status gave no irq");
   a_quiet_irq: assert property (status_o == 32'h0000_0000 |=>
      !irq_o) else $error("irq without status");
endmodule : mimb_mask_bank_asserts
bind mimb_mask_bank mimb_mask_bank_asserts chk_u (.sys_clk_i, .reset_i,
   .reg_req_i, .conv_done_i, .src_i, .temp_i, .rd_data_o, .irq_o,
   .status_o, .int_temp_value_o);
`default_nettype wire

// ### verif/test_mimb_mask_bank.sv
// Bench for the mask bank: registers, masking and temperature offset
// Assumes the package and the bound checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module test_mimb_mask_bank;
   import mimb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic conv = 1'b0;
   logic chk = 1'b0;
   logic [1:0] chk_d = 2'b00;
   mimb_reg_req_t req = '0;
   mimb_src_t src = '0;
   mimb_temp_t tmp = '{1'b0, 8'h00, 8'h50, 8'hE0};
   logic [7:0] rd;
   logic irq;
   logic [7:0] tv;
   logic [33:0] q[$];
   logic [31:0] m;
   int mismatches = 0;
   int samples_checked = 0;
   int k;
   mimb_mask_bank dut_u (.sys_clk_i(clk), .reset_i(rst), .reg_req_i(req),
      .conv_done_i(conv), .src_i(src), .temp_i(tmp), .rd_data_o(rd),
      .irq_o(irq), .status_o(), .int_temp_value_o(tv));
   initial forever #25 clk = ~clk;
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   // Note kinds: 0 read data, 1 irq, 2 corrected temperature
   task automatic cmp(input logic [33:0] e);
      logic [31:0] g;
      g = e[33] ? {24'h00_0000, tv} : e[32] ? {31'h0000_0000, irq}
         : {24'h00_0000, rd};
      samples_checked++;
      if (g !== e[31:0])
      begin
         mismatches++;
         $display("BAD %0t kind %0d got %h exp %h", $time, e[33:32], g, e);
      end
   endtask : cmp
   always @(posedge clk) chk_d <= {chk_d[0], chk};
   always @(negedge clk)
      if (chk_d[1])
         cmp(q.pop_front());
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{a, 1'b1, d};
      @(posedge clk) #1;
      req.wr = 1'b0;
   endtask : wr
   // Holds address and sources for two edges; strobes drop after one
   task automatic note(input logic [33:0] e);
      q.push_back(e);
      chk = 1'b1;
      @(posedge clk) #1;
      {chk, conv, tmp.valid} = 3'b000;
      @(posedge clk) #1;
   endtask : note
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      req.addr = a;
      note({2'b00, 24'h00_0000, e});
   endtask : rd_chk
   task automatic wm(input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         wr(8'h1A + i[7:0], v[8*i +: 8]);
   endtask : wm
   task automatic cv(input logic [31:0] s, input logic e);
      src = '{s[7:0], s[9], s[10], s[11], s[12], s[14], s[15], s[31:16]};
      conv = 1'b1;
      note({2'b01, 31'h0000_0000, e});
   endtask : cv
   task automatic tp(input logic [7:0] r, input logic [7:0] o);
      logic signed [8:0] s;
      s = $signed({r[7], r}) + $signed({o[7], o});
      wr(8'h1E, o);
      tmp.raw = r;
      tmp.valid = 1'b1;
      note({2'b10, 24'h00_0000, s > 9'sh07F ? 8'h7F : s < 9'sh180 ? 8'h80
         : s[7:0]});
   endtask : tp
   initial
   begin
      k = $urandom(87);
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      for (k = 8'h1A; k <= 8'h20; k++)
         rd_chk(k[7:0], 8'h00);
      $display("reset values done");
      for (k = 8'h1A; k <= 8'h20; k++)
      begin
         m = $urandom;
         wr(k[7:0], m[7:0]);
         rd_chk(k[7:0], k == 8'h1B ? m[7:0] & 8'hDF : k > 8'h1E ? 8'h00
            : m[7:0]);
      end
      $display("register access done");
      for (k = 0; k < 32; k++)
         if (k != 8 && k != 13)
         begin
            m = $urandom | (32'h0000_0001 << k);
            wm(m);
            cv(32'h0000_0001 << k, 1'b0);
            m[k] = 1'b0;
            wm(m);
            cv(32'h0000_0001 << k, 1'b1);
         end
      $display("mask sources done");
      tp(8'h7E, 8'h05);
      tp(8'h81, 8'hFE);
      repeat (8)
         tp($urandom, $urandom);
      tp(8'h60, 8'h00);
      rd_chk(8'h1F, 8'h60);
      wm(32'h0000_0000);
      cv(32'h0000_0000, 1'b1);
      wm(32'h0000_0100);
      cv(32'h0000_0000, 1'b0);
      @(posedge clk);
      $display("temperature done");
      summarize();
   end
   initial
   begin
      #200_000;
      mismatches++;
      summarize();
   end
endmodule : test_mimb_mask_bank
`default_nettype wire
